// ---- rtl/regctl_pkg.sv ----
// Purpose: shared constants for the regulator control register slice
// Assumes: 8-bit registers reached over a plain strobe port
// Notes:   offsets are byte addresses of the register slice
package regctl_pkg;
    localparam logic [7:0] ADDR_LINREG_TEN    = 8'h2f;
    localparam logic [7:0] ADDR_LINREG_ELEVEN = 8'h30;
    localparam logic [7:0] ADDR_VIBRATION     = 8'h31;
    localparam logic [7:0] ADDR_DVS_ONE       = 8'h32;

    // control register field positions
    localparam int SEQ_TARGET_BIT   = 7;
    localparam int VPIN_HI          = 6;
    localparam int VPIN_LO          = 5;
    localparam int VSEL_BIT         = 4;
    localparam int PD_OFF_BIT       = 3;
    localparam int EPIN_HI          = 2;
    localparam int EPIN_LO          = 1;
    localparam int ON_BIT           = 0;
    localparam int VIB_CODE_W       = 6;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] VIB_RESET  = 8'h00;
    localparam logic [7:0] DVS_RESET  = 8'h00;
    localparam logic [7:0] RDATA_RESET    = 8'h00;
    localparam logic       BRAKE_RESET    = 1'b1;
    localparam logic       PULLDOWN_RESET = 1'b0;

    // pin selector codes
    localparam logic [1:0] PIN_SEL_NONE   = 2'h0;
    localparam logic [1:0] PIN_SEL_FIRST  = 2'h1;
    localparam logic [1:0] PIN_SEL_SECOND = 2'h2;
    localparam logic [1:0] PIN_SEL_THIRTEENTH = 2'h3;

    // vibration driver full scale in millivolts and step count
    localparam int VIB_FULL_SCALE_MV = 3000;
    localparam int VIB_STEPS         = 63;

    typedef enum logic [1:0] {GPIO_FIRST, GPIO_SECOND, GPIO_THIRTEENTH} gpio_idx_t;
endpackage

// ---- rtl/regctl_bus_if.sv ----
// Purpose: pin edge bundle between the top and the pin watcher
// Assumes: one clock domain
// Notes:   carries synchronised pin edges back to the register bank
interface regctl_bus_if;
    logic [2:0] rise;
    logic [2:0] fall;
    modport watcher (output rise, output fall);
    modport bank    (input rise, input fall);
endinterface

// ---- rtl/gpio_edge_watch.sv ----
// Purpose: synchronise three control pins and flag their edges
// Assumes: pins are asynchronous to sys_clk
// Notes:   rise/fall are one-cycle pulses
module gpio_edge_watch
    import regctl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [2:0]  pins,
    regctl_bus_if.watcher    ev
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [2:0] last_reg;
    logic [2:0] rise_reg;
    logic [2:0] fall_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
            last_reg <= 3'h0;
            rise_reg <= 3'h0;
            fall_reg <= 3'h0;
        end
        else
        begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            rise_reg <= sync_reg & ~last_reg;
            fall_reg <= ~sync_reg & last_reg;
        end
    end

    assign ev.rise = rise_reg;
    assign ev.fall = fall_reg;
endmodule

// ---- rtl/regulator_control_regs.sv ----
// Purpose: control registers for two linear regulators, vibration level, ramped selects
// Assumes: 200 MHz sys_clk, synchronous active-low reset, strobe register port
// Notes:   pin inputs are asynchronous and pass two flip-flops first
//
// Summary of operation
// - top bit holds sequencer target; bit 0 is the live enable
// - voltage pin field nonzero: rising edge picks A, falling edge picks B
// - pin field 00 none, 01 first pin, 10 second pin, 11 thirteenth pin
// - software voltage bit: 0 setting A, 1 setting B, immediate
// - pull-down bit 0 connects pull-down while disabled and out of reset, 1 never
// - enable pin field nonzero: rising edge enables, falling edge disables
// - second regulator register identical, at next address
// - vibration code zero brakes: low side on, high side off
// - nonzero codes set average output linearly, 3 V over 63 steps
// - bits 7..5 select A/B ramped for third, second, first regulators
// - bits 4..0 select A/B ramped for five buck converters
module regulator_control_regs
    import regctl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [7:0]  rdata,
    input  wire logic [2:0]  gpio_pins,
    output logic             reg_ten_enable,
    output logic             reg_ten_volt_b,
    output logic             reg_ten_pulldown,
    output logic             reg_eleven_enable,
    output logic             reg_eleven_volt_b,
    output logic             reg_eleven_pulldown,
    output logic             vib_brake,
    output logic      [5:0]  vib_drive_level,
    output logic      [7:0]  ramp_select_b
);
    // ****************************************************************
    // storage and decode
    // ****************************************************************
    logic [7:0] ten_reg;
    logic [7:0] ten_next;
    logic [7:0] eleven_reg;
    logic [7:0] eleven_next;
    logic [7:0] vib_reg;
    logic [7:0] vib_next;
    logic [7:0] dvs_reg;
    logic [7:0] dvs_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    regctl_bus_if ev ();

    gpio_edge_watch u_watch
    (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .pins    (gpio_pins),
        .ev      (ev)
    );

    wire logic hit_ten    = wr_stb && (addr == ADDR_LINREG_TEN);
    wire logic hit_eleven = wr_stb && (addr == ADDR_LINREG_ELEVEN);
    wire logic hit_vib    = wr_stb && (addr == ADDR_VIBRATION);
    wire logic hit_dvs    = wr_stb && (addr == ADDR_DVS_ONE);

    function automatic logic pick_edge(input logic [1:0] sel, input logic [2:0] ev_bits);
        logic r;
        r = 1'b0;
        unique case (sel)
            PIN_SEL_NONE:       r = 1'b0;
            PIN_SEL_FIRST:      r = ev_bits[GPIO_FIRST];
            PIN_SEL_SECOND:     r = ev_bits[GPIO_SECOND];
            PIN_SEL_THIRTEENTH: r = ev_bits[GPIO_THIRTEENTH];
        endcase
        return r;
    endfunction

    // pin edges act on the live enable and the voltage select bits
    function automatic logic [7:0] apply_pins(input logic [7:0] cur,
                                              input logic [2:0] rise,
                                              input logic [2:0] fall);
        logic [7:0] r;
        r = cur;
        if (pick_edge(cur[EPIN_HI:EPIN_LO], rise))
            r[ON_BIT] = 1'b1;
        else if (pick_edge(cur[EPIN_HI:EPIN_LO], fall))
            r[ON_BIT] = 1'b0;
        if (pick_edge(cur[VPIN_HI:VPIN_LO], rise))
            r[VSEL_BIT] = 1'b0;
        else if (pick_edge(cur[VPIN_HI:VPIN_LO], fall))
            r[VSEL_BIT] = 1'b1;
        return r;
    endfunction

    function automatic logic pulldown_on(input logic [7:0] ctl);
        return ~ctl[ON_BIT] & ~ctl[PD_OFF_BIT];
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    // software write, then pin edges win
    assign ten_next = apply_pins(hit_ten ? wdata : ten_reg, ev.rise, ev.fall);
    assign eleven_next = apply_pins(hit_eleven ? wdata : eleven_reg, ev.rise, ev.fall);
    assign vib_next = hit_vib ? {2'h0, wdata[VIB_CODE_W-1:0]} : vib_reg;
    assign dvs_next = hit_dvs ? wdata : dvs_reg;

    always_comb
    begin
        rdata_next = 8'h00;
        if (rd_stb)
        begin
            unique case (addr)
                ADDR_LINREG_TEN:    rdata_next = ten_reg;
                ADDR_LINREG_ELEVEN: rdata_next = eleven_reg;
                ADDR_VIBRATION:     rdata_next = vib_reg;
                ADDR_DVS_ONE:       rdata_next = dvs_reg;
                default:            rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ten_reg <= CTRL_RESET;
        end
        else
        begin
            ten_reg <= ten_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            eleven_reg <= CTRL_RESET;
        end
        else
        begin
            eleven_reg <= eleven_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            vib_reg <= VIB_RESET;
        end
        else
        begin
            vib_reg <= vib_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            dvs_reg <= DVS_RESET;
        end
        else
        begin
            dvs_reg <= dvs_next;
        end
    end

    // registered read data
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rdata_reg <= RDATA_RESET;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    wire logic       ten_enable_next      = ten_next[ON_BIT];
    wire logic       ten_volt_b_next      = ten_next[VSEL_BIT];
    wire logic       ten_pulldown_next    = pulldown_on(ten_next);
    wire logic       eleven_enable_next   = eleven_next[ON_BIT];
    wire logic       eleven_volt_b_next   = eleven_next[VSEL_BIT];
    wire logic       eleven_pulldown_next = pulldown_on(eleven_next);
    wire logic [5:0] vib_level_next       = vib_next[VIB_CODE_W-1:0];
    wire logic       brake_next           = (vib_level_next == 6'h00);

    logic       ten_enable_reg;
    logic       ten_volt_b_reg;
    logic       ten_pulldown_reg;
    logic       eleven_enable_reg;
    logic       eleven_volt_b_reg;
    logic       eleven_pulldown_reg;
    logic       brake_reg;
    logic [5:0] vib_level_reg;
    logic [7:0] ramp_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ten_enable_reg <= CTRL_RESET[ON_BIT];
        end
        else
        begin
            ten_enable_reg <= ten_enable_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ten_volt_b_reg <= CTRL_RESET[VSEL_BIT];
        end
        else
        begin
            ten_volt_b_reg <= ten_volt_b_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ten_pulldown_reg <= PULLDOWN_RESET;
        end
        else
        begin
            ten_pulldown_reg <= ten_pulldown_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            eleven_enable_reg <= CTRL_RESET[ON_BIT];
        end
        else
        begin
            eleven_enable_reg <= eleven_enable_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            eleven_volt_b_reg <= CTRL_RESET[VSEL_BIT];
        end
        else
        begin
            eleven_volt_b_reg <= eleven_volt_b_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            eleven_pulldown_reg <= PULLDOWN_RESET;
        end
        else
        begin
            eleven_pulldown_reg <= eleven_pulldown_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            brake_reg <= BRAKE_RESET;
        end
        else
        begin
            brake_reg <= brake_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            vib_level_reg <= VIB_RESET[VIB_CODE_W-1:0];
        end
        else
        begin
            vib_level_reg <= vib_level_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ramp_reg <= DVS_RESET;
        end
        else
        begin
            ramp_reg <= dvs_next;
        end
    end

    assign rdata               = rdata_reg;
    assign reg_ten_enable      = ten_enable_reg;
    assign reg_ten_volt_b      = ten_volt_b_reg;
    assign reg_ten_pulldown    = ten_pulldown_reg;
    assign reg_eleven_enable   = eleven_enable_reg;
    assign reg_eleven_volt_b   = eleven_volt_b_reg;
    assign reg_eleven_pulldown = eleven_pulldown_reg;
    assign vib_brake           = brake_reg;
    assign vib_drive_level     = vib_level_reg;
    assign ramp_select_b       = ramp_reg;
endmodule

// ---- tb/regctl_props.sv ----
// Purpose: port assertions for the regulator register slice
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to regulator_control_regs by the bind below
module regctl_props
    import regctl_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       reg_ten_enable,
    input wire logic       reg_ten_volt_b,
    input wire logic       reg_ten_pulldown,
    input wire logic       reg_eleven_enable,
    input wire logic       reg_eleven_volt_b,
    input wire logic       vib_brake,
    input wire logic [5:0] vib_drive_level,
    input wire logic [7:0] ramp_select_b
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire wr_ten = wr_stb && addr == ADDR_LINREG_TEN;
    wire wr_el  = wr_stb && addr == ADDR_LINREG_ELEVEN;
    ten_enable_a: assert property (wr_ten |=> reg_ten_enable == $past(wdata[0]))
        else $error("enable does not follow write");
    ten_volt_a: assert property (wr_ten |=> reg_ten_volt_b == $past(wdata[4]))
        else $error("voltage select does not follow write");
    pulldown_state_a: assert property (wr_ten |=> reg_ten_pulldown ==
        !($past(wdata[0]) || $past(wdata[3]))) else $error("pull-down wrong");
    eleven_copy_a: assert property (wr_el |=> reg_eleven_enable == $past(wdata[0])
        && reg_eleven_volt_b == $past(wdata[4])) else $error("second regulator wrong");
    vib_brake_a: assert property (vib_brake == (vib_drive_level == 6'h00))
        else $error("brake state wrong");
    vib_level_a: assert property (wr_stb && addr == ADDR_VIBRATION |=>
        vib_drive_level == $past(wdata[5:0])) else $error("drive level wrong");
    vib_reserved_a: assert property (rd_stb && addr == ADDR_VIBRATION |=>
        rdata[7:6] == 2'h0) else $error("reserved bits read nonzero");
    ramp_select_a: assert property (wr_stb && addr == ADDR_DVS_ONE |=>
        ramp_select_b == $past(wdata)) else $error("ramp selects wrong");
    cover property ($rose(reg_ten_enable));
    cover property ($fell(vib_brake));
    cover property ($changed(ramp_select_b));
endmodule
bind regulator_control_regs regctl_props regctl_props_i (.sys_clk(sys_clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .reg_ten_enable(reg_ten_enable), .reg_ten_volt_b(reg_ten_volt_b),
    .reg_ten_pulldown(reg_ten_pulldown), .reg_eleven_enable(reg_eleven_enable),
    .reg_eleven_volt_b(reg_eleven_volt_b), .vib_brake(vib_brake),
    .vib_drive_level(vib_drive_level), .ramp_select_b(ramp_select_b));

// ---- tb/pin_model.sv ----
// Purpose: control pins driven from outside the device
// Assumes: pins are plain push-pull levels
// Notes:   moves off the clock grid so the synchroniser is exercised
module pin_model
(
    input  wire logic [2:0] want,
    output wire logic [2:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // levels settle off the clock edge
    assign #1.3 pins = want;
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the regulator register slice
// Assumes: strobe register port, pins via pin_model
// Notes:   expectations come from the field layout only
module tb_top
    import regctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // bench
    // ****
    logic       sys_clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ramp;
    logic [2:0] want = 3'h0, pins;
    logic       t_en, t_vb, t_pd, e_en, e_vb, e_pd, brake;
    logic [5:0] lvl;
    int         miscompares = 0, check_count = 0, cycles = 0;
    regulator_control_regs regulator_control_regs_i (.sys_clk(sys_clk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .gpio_pins(pins), .reg_ten_enable(t_en), .reg_ten_volt_b(t_vb),
        .reg_ten_pulldown(t_pd), .reg_eleven_enable(e_en), .reg_eleven_volt_b(e_vb),
        .reg_eleven_pulldown(e_pd), .vib_brake(brake), .vib_drive_level(lvl),
        .ramp_select_b(ramp));
    pin_model pin_model_i (.want(want), .pins(pins));
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            stop_test();
        end
    end
    task stop_test;
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task t_regs;
        for (int i = 0; i < 4; i++)
            rd(ADDR_LINREG_TEN + i[7:0], 8'h00);
        chk({7'h0, brake}, 8'h01);
        wr(ADDR_LINREG_TEN, 8'h99);
        rd(ADDR_LINREG_TEN, 8'h99);
        chk({t_en, t_vb, t_pd, e_en, e_vb, e_pd}, 8'h31);
        wr(ADDR_LINREG_TEN, 8'h00);
        chk({t_en, t_vb, t_pd}, 8'h01);
        wr(ADDR_LINREG_ELEVEN, 8'h19);
        rd(ADDR_LINREG_ELEVEN, 8'h19);
        chk({t_en, t_pd, e_en, e_vb, e_pd}, 8'h0e);
        wr(ADDR_VIBRATION, 8'hff);
        rd(ADDR_VIBRATION, 8'h3f);
        chk({brake, 1'b0, lvl}, 8'h3f);
        wr(ADDR_VIBRATION, 8'h00);
        chk({brake, 1'b0, lvl}, 8'h80);
        wr(ADDR_DVS_ONE, 8'ha5);
        rd(ADDR_DVS_ONE, 8'ha5);
        chk(ramp, 8'ha5);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
    endtask
    task pin_step(input int p, input logic lv, input logic [7:0] exp);
        @(posedge sys_clk);
        want[p] <= lv;
        repeat (6) @(posedge sys_clk);
        #1;
        chk({t_en, t_vb}, exp);
    endtask
    task t_pins;
        wr(ADDR_LINREG_TEN, 8'h00);
        pin_step(0, 1'b1, 8'h00);
        pin_step(0, 1'b0, 8'h00);
        for (int s = 1; s < 4; s++)
        begin
            wr(ADDR_LINREG_TEN, {1'b0, s[1:0], 1'b1, 1'b0, s[1:0], 1'b0});
            pin_step(s - 1, 1'b1, 8'h02);
            pin_step(s - 1, 1'b0, 8'h01);
        end
        // second regulator on the second pin; the first stays on the thirteenth
        wr(ADDR_LINREG_ELEVEN, 8'h54);
        pin_step(1, 1'b1, 8'h01);
        chk({e_en, e_vb}, 8'h02);
        pin_step(1, 1'b0, 8'h01);
        chk({e_en, e_vb}, 8'h01);
    endtask
    task t_reset;
        wr(ADDR_VIBRATION, 8'h15);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({t_en, t_vb, t_pd, e_en, e_vb, e_pd}, 8'h09);
        chk({brake, 1'b0, lvl}, 8'h80);
        rd(ADDR_LINREG_TEN, 8'h00);
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_pins();
        t_reset();
        stop_test();
    end
endmodule
